// ---- verilog/tlc_top.sv ----
// Top-level interrupt configuration, nesting state and APB registers
//
// The APB register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module tlc_top (
  input  wire logic                      clock_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      ce_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [tlc_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [tlc_pkg::DATA_W-1:0] pwdata_i,
  input  wire logic [3:0]                pstrb_i,
  output var  logic                      pready_o,
  output var  logic [tlc_pkg::DATA_W-1:0] prdata_o,
  output var  logic                      pslverr_o,
  input  wire logic                      nmi_pin_i,
  input  wire logic                      a0_pin_i,
  input  wire logic                      memory_stretch_pin_i,
  input  wire logic                      wdog_eoc_i,
  input  wire tlc_pkg::tlc_core_in_t     core_i,
  output var  tlc_pkg::tlc_core_out_t    core_o,
  output var  logic                      channel_a0_input_o,
  output var  logic                      memory_stretch_o,
  output var  logic                      irq_o
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [7:0]                page_r;
  logic [3:0]                vec_hi_r;
  logic [3:0]                vec_lo_r;
  logic                      seg_stack_r;
  logic                      top_level_unmaskable_r;
  logic [tlc_pkg::HOLD_W-1:0] hold_r;
  logic                      gate_r;
  logic                      pend_r;
  logic [tlc_pkg::STAT_W-1:0] stat_r;
  logic [tlc_pkg::STAT_W-1:0] mask_r;
  tlc_pkg::tlc_ext_t         ext_r;
  logic                      nmi_lvl;
  logic                      a0_lvl;
  logic                      str_lvl;
  logic                      nmi_edge;
  logic                      tl_trig;
  logic                      hit;
  logic                      wr_en;
  logic                      sw_pend_set;
  logic                      hold_set;
  logic                      hold_clr;
  logic [tlc_pkg::HOLD_W-1:0] hold_nxt;
  logic [tlc_pkg::DATA_W-1:0] rd_nxt;
  logic [7:0]                idx;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  // Word index from a byte address
  function automatic logic [7:0] reg_idx(
    input logic [tlc_pkg::ADDR_W-1:0] a
  );
    reg_idx = a[9:2];
  endfunction

  // True when the address names an implemented register
  function automatic logic reg_hit(
    input logic [tlc_pkg::ADDR_W-1:0] a
  );
    logic [7:0] i;
    i = reg_idx(a);
    reg_hit = (a[1:0] == tlc_pkg::WORD_ALN) &&
              (a[tlc_pkg::ADDR_W-1:10] == '0) &&
              (i == tlc_pkg::IDX_PAGE || i == tlc_pkg::IDX_CTRL ||
               i == tlc_pkg::IDX_STAT || i == tlc_pkg::IDX_MASK ||
               i == tlc_pkg::IDX_VEC  || i == tlc_pkg::IDX_NEST);
  endfunction

  assign idx = reg_idx(paddr_i);
  assign hit = reg_hit(paddr_i);

  // ------------------------------------------------------------
  // Pin conditioning
  // ------------------------------------------------------------
  tlc_sync3 u_sync_nmi (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .pin_i     (nmi_pin_i),
    .level_o   (nmi_lvl)
  );

  tlc_sync3 u_sync_a0 (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .pin_i     (a0_pin_i),
    .level_o   (a0_lvl)
  );

  tlc_sync3 u_sync_str (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .pin_i     (memory_stretch_pin_i),
    .level_o   (str_lvl)
  );

  tlc_edge u_edge_nmi (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .level_i   (nmi_lvl),
    .rise_i    (vec_lo_r[tlc_pkg::VEC_EDGE]),
    .pulse_o   (nmi_edge)
  );

  // Top-level trigger source
  assign tl_trig = vec_lo_r[tlc_pkg::VEC_TLSRC] ? nmi_edge
                                                : wdog_eoc_i;

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  // Zero-wait access phase; error on unmapped address
  assign pready_o  = psel_i & penable_i & ce_i;
  assign pslverr_o = pready_o & ~hit;
  assign wr_en     = pready_o & pwrite_i & hit & pstrb_i[0];

  // Read mux
  always_comb begin
    rd_nxt = '0;
    unique case (idx)
      tlc_pkg::IDX_PAGE: rd_nxt[7:0] = page_r;
      tlc_pkg::IDX_CTRL: begin
        rd_nxt[tlc_pkg::CTRL_GATE] = gate_r;
        rd_nxt[tlc_pkg::CTRL_PEND] = pend_r;
      end
      tlc_pkg::IDX_STAT: rd_nxt[tlc_pkg::STAT_W-1:0] = stat_r;
      tlc_pkg::IDX_MASK: rd_nxt[tlc_pkg::STAT_W-1:0] = mask_r;
      tlc_pkg::IDX_VEC: begin
        if (page_r == tlc_pkg::PAGE_XMEM) begin
          rd_nxt[7:0] = tlc_pkg::XMEM_RST;
          rd_nxt[tlc_pkg::XMEM_SEG] = seg_stack_r;
        end else begin
          rd_nxt[7:0] = {vec_hi_r, vec_lo_r};
        end
      end
      tlc_pkg::IDX_NEST: rd_nxt[7:0] = {top_level_unmaskable_r, hold_r};
      default: rd_nxt = '0;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      prdata_o <= '0;
    end else if (ce_i && psel_i && !penable_i) begin
      prdata_o <= rd_nxt;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  // Upper vector nibble has no reset
  always_ff @(posedge clock_i) begin
    if (ce_i && wr_en && idx == tlc_pkg::IDX_VEC &&
        page_r != tlc_pkg::PAGE_XMEM) begin
      vec_hi_r <= pwdata_i[7:4];
    end
  end

  // Lower vector nibble, page, gate, mask, stacking
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      vec_lo_r    <= tlc_pkg::VEC_LO_RST;
      page_r      <= tlc_pkg::PAGE_INTR;
      gate_r      <= 1'b0;
      mask_r      <= '0;
      seg_stack_r <= tlc_pkg::XMEM_RST[tlc_pkg::XMEM_SEG];
    end else if (ce_i && wr_en) begin
      unique case (idx)
        tlc_pkg::IDX_PAGE: page_r <= pwdata_i[7:0];
        tlc_pkg::IDX_CTRL: gate_r <= pwdata_i[tlc_pkg::CTRL_GATE];
        tlc_pkg::IDX_MASK: mask_r <= pwdata_i[tlc_pkg::STAT_W-1:0];
        tlc_pkg::IDX_VEC: begin
          if (page_r == tlc_pkg::PAGE_XMEM) begin
            seg_stack_r <= pwdata_i[tlc_pkg::XMEM_SEG];
          end else begin
            vec_lo_r <= pwdata_i[3:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Unmaskable lock: software sets, only reset clears
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      top_level_unmaskable_r <= tlc_pkg::NEST_RST[tlc_pkg::NEST_TOP_LEVEL_UNMASKABLE];
    end else if (ce_i && wr_en && idx == tlc_pkg::IDX_NEST &&
                 pwdata_i[tlc_pkg::NEST_TOP_LEVEL_UNMASKABLE]) begin
      top_level_unmaskable_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Top-level pending and request
  // ------------------------------------------------------------
  assign sw_pend_set = wr_en && idx == tlc_pkg::IDX_CTRL &&
                       pwdata_i[tlc_pkg::CTRL_PEND];

  // Set by trigger or software wins over acknowledge
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pend_r <= 1'b0;
    end else if (ce_i) begin
      if (tl_trig || sw_pend_set) begin
        pend_r <= 1'b1;
      end else if (core_i.tl_ack) begin
        pend_r <= 1'b0;
      end
    end
  end

  // Request gating
  assign core_o.tl_req = top_level_unmaskable_r ? pend_r
                                : (core_i.glob_en & gate_r & pend_r);

  // ------------------------------------------------------------
  // Hold-level bits
  // ------------------------------------------------------------
  assign hold_set = core_i.nested && core_i.preempt &&
                    !core_i.preempt_by_tl &&
                    core_i.preempt_lvl < 3'(tlc_pkg::HOLD_W);
  assign hold_clr = core_i.iret &&
                    core_i.iret_lvl < 3'(tlc_pkg::HOLD_W);

  // Per-level update, set wins on the same bit
  always_comb begin
    for (int i = 0; i < tlc_pkg::HOLD_W; i++) begin
      if (hold_set && core_i.preempt_lvl == 3'(i)) begin
        hold_nxt[i] = 1'b1;
      end else if (hold_clr && core_i.iret_lvl == 3'(i)) begin
        hold_nxt[i] = 1'b0;
      end else begin
        hold_nxt[i] = hold_r[i];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      hold_r <= tlc_pkg::NEST_RST[tlc_pkg::HOLD_W-1:0];
    end else if (ce_i) begin
      hold_r <= hold_nxt;
    end
  end

  // ------------------------------------------------------------
  // Event status and interrupt
  // ------------------------------------------------------------
  // Sticky events, write one to clear, set wins
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      stat_r <= '0;
    end else if (ce_i) begin
      stat_r <= (stat_r & ~((wr_en && idx == tlc_pkg::IDX_STAT) ?
                 pwdata_i[tlc_pkg::STAT_W-1:0] : '0))
                | {hold_set, tl_trig};
    end
  end

  assign irq_o = |(stat_r & mask_r);

  // ------------------------------------------------------------
  // Channel A0 and memory stretch
  // ------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      channel_a0_input_o <= 1'b0;
      memory_stretch_o   <= 1'b0;
    end else if (ce_i) begin
      channel_a0_input_o <= vec_lo_r[tlc_pkg::VEC_A0SRC] ? a0_lvl
                                                         : wdog_eoc_i;
      memory_stretch_o   <= vec_lo_r[tlc_pkg::VEC_STRETCH] & str_lvl;
    end
  end

  // ------------------------------------------------------------
  // Segment stacking and entry extension
  // ------------------------------------------------------------
  assign core_o.push_cs    = seg_stack_r;
  assign core_o.load_cs    = seg_stack_r;
  assign core_o.restore_cs = seg_stack_r;
  assign core_o.use_hseg   = ~seg_stack_r;

  // Two extra cycles after entry when the segment is pushed
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ext_r <= tlc_pkg::TLC_IDLE;
    end else if (ce_i) begin
      unique case (ext_r)
        tlc_pkg::TLC_IDLE: begin
          if (core_i.entry && seg_stack_r) begin
            ext_r <= tlc_pkg::TLC_EXT1;
          end
        end
        tlc_pkg::TLC_EXT1: ext_r <= tlc_pkg::TLC_EXT2;
        tlc_pkg::TLC_EXT2: ext_r <= tlc_pkg::TLC_IDLE;
        default:           ext_r <= tlc_pkg::TLC_IDLE;
      endcase
    end
  end

  assign core_o.entry_stretch = (ext_r != tlc_pkg::TLC_IDLE);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i || !ce_i);

  a_vec_low_reset: assert property (
    disable iff (!ce_i)
    sys_rst_i ##1 ce_i |-> vec_lo_r == tlc_pkg::VEC_LO_RST)
    else $error("vector low nibble not 0110 after reset");

  a_top_level_unmaskable_sticky: assert property (
    top_level_unmaskable_r |=> top_level_unmaskable_r)
    else $error("unmaskable lock cleared without reset");

  a_req_masked: assert property (
    core_o.tl_req && !top_level_unmaskable_r |-> core_i.glob_en && gate_r && pend_r)
    else $error("maskable request without enable, gate and pending");

  a_req_unmask: assert property (
    top_level_unmaskable_r && pend_r |-> core_o.tl_req)
    else $error("unmaskable pending without request");

  a_pend_trig: assert property (
    tl_trig |=> pend_r)
    else $error("trigger did not set pending");

  a_pend_ack: assert property (
    core_i.tl_ack && !tl_trig && !sw_pend_set |=> !pend_r)
    else $error("acknowledge did not clear pending");

  a_hold_set_lvl: assert property (
    hold_set |=> hold_r[$past(core_i.preempt_lvl)])
    else $error("preemption did not set hold bit");

  a_hold_clr_lvl: assert property (
    hold_clr && !hold_set |=> !hold_r[$past(core_i.iret_lvl)])
    else $error("return did not clear hold bit");

  a_stretch_gate: assert property (
    !vec_lo_r[tlc_pkg::VEC_STRETCH] ##1 1 |-> !memory_stretch_o)
    else $error("stretch passed while disabled");

  a_entry_ext_two: assert property (
    core_i.entry && seg_stack_r && ext_r == tlc_pkg::TLC_IDLE |=>
      core_o.entry_stretch [*2] ##1 !core_o.entry_stretch)
    else $error("entry extension not exactly two cycles");

  a_seg_modes: assert property (
    core_o.use_hseg != core_o.push_cs)
    else $error("segment modes disagree");

  c_tl_request: cover property (tl_trig ##[1:3] core_o.tl_req);
  c_hold_set:   cover property (hold_set ##1 hold_clr);
  c_entry_ext:  cover property (core_o.entry_stretch [*2]);
  c_irq:        cover property (irq_o);

endmodule
`default_nettype wire

// ---- verilog/tlc_pkg.sv ----
// Constants, register map and carrier types of the top-level interrupt block
package tlc_pkg;

  // ------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------
  localparam int          ADDR_W   = 12;
  localparam int          DATA_W   = 32;
  localparam logic [1:0]  WORD_ALN = 2'h0;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_PAGE = 8'h00;
  localparam logic [7:0] IDX_CTRL = 8'h01;
  localparam logic [7:0] IDX_STAT = 8'h02;
  localparam logic [7:0] IDX_MASK = 8'h03;
  localparam logic [7:0] IDX_VEC  = 8'hf6;
  localparam logic [7:0] IDX_NEST = 8'hf7;

  // Register pages sharing the index of the vector register
  localparam logic [7:0] PAGE_INTR = 8'h00;
  localparam logic [7:0] PAGE_XMEM = 8'h15;

  // ------------------------------------------------------------
  // Reset values and field positions
  // ------------------------------------------------------------
  localparam logic [3:0] VEC_LO_RST  = 4'h6;
  localparam logic [7:0] XMEM_RST    = 8'h0f;
  localparam logic [7:0] NEST_RST    = 8'h00;
  localparam int         VEC_EDGE    = 3;
  localparam int         VEC_TLSRC   = 2;
  localparam int         VEC_A0SRC   = 1;
  localparam int         VEC_STRETCH = 0;
  localparam int         NEST_TOP_LEVEL_UNMASKABLE   = 7;
  localparam int         XMEM_SEG    = 6;
  localparam int         CTRL_GATE   = 0;
  localparam int         CTRL_PEND   = 1;
  localparam int         STAT_TL     = 0;
  localparam int         STAT_HOLD   = 1;
  localparam int         STAT_W      = 2;
  localparam int         HOLD_W      = 7;
  localparam int         LVL_W       = 3;

  // ------------------------------------------------------------
  // Timing: extra entry cycles when the code segment is pushed
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SEG_PUSH_CYC  = 2;

  // Entry-extension sequencer, Gray coded
  typedef enum logic [1:0] {
    TLC_IDLE = 2'b00,
    TLC_EXT1 = 2'b01,
    TLC_EXT2 = 2'b11
  } tlc_ext_t;

  // Events from the core interrupt sequencer
  typedef struct packed {
    logic             preempt;
    logic [LVL_W-1:0] preempt_lvl;
    logic             preempt_by_tl;
    logic             iret;
    logic [LVL_W-1:0] iret_lvl;
    logic             tl_ack;
    logic             entry;
    logic             nested;
    logic             glob_en;
  } tlc_core_in_t;

  // Controls back to the core interrupt sequencer
  typedef struct packed {
    logic tl_req;
    logic push_cs;
    logic load_cs;
    logic restore_cs;
    logic use_hseg;
    logic entry_stretch;
  } tlc_core_out_t;

endpackage

// ---- verilog/tlc_sync3.sv ----
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module tlc_sync3 (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  input  wire logic pin_i,
  output var  logic level_o
);
  logic ff1_r;
  logic ff2_r;
  logic ff3_r;

  // ------------------------------------------------------------
  // Chain and filter
  // ------------------------------------------------------------
  // First flop is read only by the second
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ff1_r <= 1'b0;
      ff2_r <= 1'b0;
      ff3_r <= 1'b0;
    end else if (ce_i) begin
      ff1_r <= pin_i;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
    end
  end

  // Level moves only once second and third agree
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      level_o <= 1'b0;
    end else if (ce_i && (ff2_r == ff3_r)) begin
      level_o <= ff3_r;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/tlc_edge.sv ----
// Selectable-polarity edge detector producing a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module tlc_edge (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  input  wire logic level_i,
  input  wire logic rise_i,
  output var  logic pulse_o
);
  logic prev_r;

  // ------------------------------------------------------------
  // Edge pulse
  // ------------------------------------------------------------
  // One pulse per filtered transition of the chosen polarity
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      prev_r  <= 1'b0;
      pulse_o <= 1'b0;
    end else if (ce_i) begin
      prev_r  <= level_i;
      pulse_o <= rise_i ? (level_i & ~prev_r)
                        : (~level_i & prev_r);
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tlc_core_model.sv ----
// Core sequencer and pin model facing the block
`timescale 1ns/10ps
`default_nettype none
module tlc_core_model (
  input  wire tlc_pkg::tlc_core_out_t core_out_i,
  input  wire logic                   clock_i,
  output var  tlc_pkg::tlc_core_in_t  core_in_o,
  output var  logic                   nmi_o,
  output var  logic                   a0_o,
  output var  logic                   stretch_o,
  output var  logic                   wdog_o,
  output var  int                     acks_o
);
  initial begin
    core_in_o = '0;
    nmi_o = 1'b0;
    a0_o = 1'b0;
    stretch_o = 1'b0;
    wdog_o = 1'b0;
    acks_o = 0;
  end

  // Acknowledge each top-level request once
  always @(posedge clock_i) begin
    core_in_o.tl_ack <= core_out_i.tl_req && !core_in_o.tl_ack;
    if (core_out_i.tl_req && !core_in_o.tl_ack)
      acks_o <= acks_o + 1;
  end

  // One-cycle event: 0 preempt, 1 by top level, 2 return, 3 entry, 4 wdog
  task automatic ev(input int k, input logic [2:0] lvl);
    @(posedge clock_i);
    core_in_o.preempt <= (k < 2);
    core_in_o.preempt_by_tl <= (k == 1);
    core_in_o.preempt_lvl <= lvl;
    core_in_o.iret <= (k == 2);
    core_in_o.iret_lvl <= lvl;
    core_in_o.entry <= (k == 3);
    wdog_o <= (k == 4);
    @(posedge clock_i);
    core_in_o.preempt <= 1'b0;
    core_in_o.iret <= 1'b0;
    core_in_o.entry <= 1'b0;
    wdog_o <= 1'b0;
  endtask

  // Global enable and nesting mode levels
  task automatic mode(input logic g, input logic n);
    core_in_o.glob_en <= g;
    core_in_o.nested <= n;
  endtask

  // Pin levels, changed after an edge
  task automatic pin(input logic nmi, input logic a0, input logic st);
    nmi_o <= nmi;
    a0_o <= a0;
    stretch_o <= st;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the top-level interrupt block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [11:0] A_PAGE = 12'h000;
  localparam logic [11:0] A_CTRL = 12'h004;
  localparam logic [11:0] A_STAT = 12'h008;
  localparam logic [11:0] A_MASK = 12'h00c;
  localparam logic [11:0] A_VEC = {2'h0, tlc_pkg::IDX_VEC, 2'h0};
  localparam logic [11:0] A_NEST = {2'h0, tlc_pkg::IDX_NEST, 2'h0};
  localparam logic [31:0] M = 32'hffff_ffff;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic ce = 1'b1;
  logic pready, pslverr, nmi, a0, st, wdog, ch_a0, mem_st, irq, err;
  logic [31:0] prdata, q;
  tlc_pkg::tlc_core_in_t core_in;
  tlc_pkg::tlc_core_out_t core_out;
  int acks, n;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;

  always #12.5 clk = ~clk;

  tlc_top u_tlc_top (.clock_i(clk), .sys_rst_i(sys_rst), .ce_i(ce),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .nmi_pin_i(nmi), .a0_pin_i(a0), .memory_stretch_pin_i(st),
    .wdog_eoc_i(wdog), .core_i(core_in), .core_o(core_out),
    .channel_a0_input_o(ch_a0), .memory_stretch_o(mem_st), .irq_o(irq));

  tlc_core_model u_tlc_core_model (.core_out_i(core_out), .clock_i(clk),
    .core_in_o(core_in), .nmi_o(nmi), .a0_o(a0), .stretch_o(st),
    .wdog_o(wdog), .acks_o(acks));

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic conclude();
    if (err_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("BAD %0t got %h want %h", $time, got, exp);
      err_count++;
    end
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic reset_dut();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  // Count stretched entry cycles after one entry pulse
  task automatic cnt_stretch(output int c);
    c = 0;
    u_tlc_core_model.ev(3, 3'h0);
    repeat (5) begin
      #1;
      if (core_out.entry_stretch === 1'b1)
        c++;
      @(posedge clk);
    end
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    reset_dut();
    rd(A_VEC, 32'h6, 32'hf);
    rd(A_NEST, 32'h0, M);
    wr(A_VEC, 32'ha0);
    u_tlc_core_model.pin(1'b0, 1'b0, 1'b1);
    wt(8);
    chk(32'(mem_st), 32'h0);
    wr(A_VEC, 32'ha1);
    wt(8);
    chk(32'(mem_st), 32'h1);
    wr(A_VEC, 32'ha0);
    u_tlc_core_model.ev(4, 3'h0);
    #1 chk(32'(ch_a0), 32'h1);
    u_tlc_core_model.pin(1'b0, 1'b1, 1'b0);
    wr(A_VEC, 32'ha2);
    wt(8);
    chk(32'(ch_a0), 32'h1);
    u_tlc_core_model.pin(1'b0, 1'b0, 1'b0);
    wt(8);
    chk(32'(ch_a0), 32'h0);
    rd(A_CTRL, 32'h2, M);
    rd(A_STAT, 32'h1, 32'h1);
    chk(32'(core_out.tl_req), 32'h0);
    chk(32'(irq), 32'h0);
    wr(A_MASK, 32'h3);
    #1 chk(32'(irq), 32'h1);
    wr(A_STAT, 32'h1);
    #1 chk(32'(irq), 32'h0);
    u_tlc_core_model.mode(1'b1, 1'b0);
    wr(A_CTRL, 32'h1);
    wt(4);
    chk(acks, 1);
    rd(A_CTRL, 32'h1, M);
    // Falling mode: wrong edge leaves pending clear; in both modes the right edge sets it once
    for (int e = 0; e < 2; e++) begin
      wr(A_CTRL, 32'h0);
      wr(A_VEC, 32'ha4 | (32'(e) << 3));
      u_tlc_core_model.pin(!e[0], 1'b0, 1'b0);
      wt(8);
      rd(A_CTRL, 32'h0, M);
      u_tlc_core_model.pin(e[0], 1'b0, 1'b0);
      wt(8);
      rd(A_CTRL, 32'h2, M);
      wr(A_CTRL, 32'h1);
      wt(4);
      rd(A_CTRL, 32'h1, M);
    end
    chk(acks, 3);
    u_tlc_core_model.mode(1'b0, 1'b1);
    wr(A_CTRL, 32'h3);
    wt(4);
    rd(A_CTRL, 32'h3, M);
    wr(A_NEST, 32'h80);
    wt(4);
    rd(A_CTRL, 32'h1, M);
    wr(A_NEST, 32'h0);
    rd(A_NEST, 32'h80, M);
    u_tlc_core_model.ev(0, 3'h3);
    rd(A_NEST, 32'h88, M);
    u_tlc_core_model.ev(1, 3'h5);
    rd(A_NEST, 32'h88, M);
    rd(A_STAT, 32'h2, 32'h2);
    u_tlc_core_model.ev(2, 3'h3);
    rd(A_NEST, 32'h80, M);
    reset_dut();
    rd(A_VEC, 32'ha6, M);
    rd(A_NEST, 32'h0, M);
    cnt_stretch(n);
    chk(n, 0);
    chk(32'(core_out.use_hseg), 32'h1);
    wr(A_PAGE, 32'h15);
    rd(A_VEC, 32'h0f, M);
    wr(A_VEC, 32'h4f);
    rd(A_VEC, 32'h4f, M);
    chk(32'({core_out.push_cs, core_out.load_cs, core_out.restore_cs,
             core_out.use_hseg}), 32'he);
    cnt_stretch(n);
    chk(n, 2);
    // Clock enable low freezes the entry sequencer
    ce <= 1'b0;
    cnt_stretch(n);
    chk(n, 0);
    ce <= 1'b1;
    wr(A_PAGE, 32'h0);
    rd(A_VEC, 32'ha6, M);
    apb(1'b0, 12'h010, 32'h0);
    chk(32'(err), 32'h1);
    conclude();
  end
endmodule
`default_nettype wire
